//--- include/whu_pkg.sv
package whu_pkg;
  // Clock rate and default line rate
  localparam int unsigned CLK_HZ       = 100000000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  // Cycles per bit at the default rate, rounded down
  localparam int unsigned DIV_DEFAULT  = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned DIV_W        = 16;
  localparam int unsigned DATA_W       = 8;
  // Settling time after reset before the receive-ready line is asserted, in us
  localparam int unsigned READY_US     = 10;
  localparam int unsigned READY_CYC    = (READY_US * (CLK_HZ / 1000000));
  localparam int unsigned READY_W      = 12;
  // Parity encodings
  localparam logic [1:0]  PAR_NONE     = 2'h0;
  localparam logic [1:0]  PAR_EVEN     = 2'h1;
  localparam logic [1:0]  PAR_ODD      = 2'h2;
  // Power-save mode codes
  localparam logic [2:0]  PS_OFF       = 3'h0;
  localparam logic [2:0]  PS_MODE1     = 3'h1;
  localparam logic [2:0]  PS_MODE5     = 3'h5;
  localparam logic [2:0]  PS_MODE6     = 3'h6;

  // Serial line configuration
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [1:0]       parity;
    logic             two_stop;
  } whu_cfg_t;

  // Received word and its error flags
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              par_err;
    logic              frm_err;
  } whu_rx_t;

  // Serialiser states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_PAR   = 3'h3,
    ST_STOP  = 3'h4
  } whu_st_t;

  // Parity bit for a word, odd for odd mode and even for any other mode
  function automatic logic whu_par(input logic [DATA_W-1:0] d, input logic [1:0] p);
    return (p == PAR_ODD) ? ~(^d) : (^d);
  endfunction
endpackage

//--- verilog/whu_uart.sv
`timescale 1ns/1ps
// Summary of operation
// - Async serial port with V.24 DCE handshaking
// - Line sense inverted from RS-232 cable
// - Selectable baud, parity, stop bits, flow
// - No auto-baud; host matches configured rate
// - Power-up default 115200, 8N1
// - Transmit on module-to-host serial line
// - Receive on host-to-module serial line
// - Receive-ready output is active low
// - Autorun runs when inhibit deasserted
// - Autorun skipped when inhibit asserted
// - Script sets spare modem line behaviour
// - Three coexistence pins, 2/3-wire schemes
// - Radio sleeps between receive wake intervals
// - Mode 1: radio saves, controller awake
// - Mode 5: radio off, await commands
// - Mode 6: radio off, standby, pin wake
// - Mode 1 refused in ad-hoc operation
// - Ready deasserted after reset until ready
module whu_uart #(
  parameter int unsigned DIV_INIT = whu_pkg::DIV_DEFAULT,  // Cycles per bit at power-up
  parameter int unsigned READY_CYCLES = whu_pkg::READY_CYC // Reset settling count
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_resetn,
  // Serial lines, active-low sense on the wire
  input  wire logic                        i_host_txd_n,
  output logic                             o_module_rxd_n,
  output logic                             o_rx_ready_n,
  input  wire logic                        i_host_ready_n,
  input  wire logic                        i_autorun_inhibit_n,
  // Line configuration from the controller
  input  wire logic                        i_cfg_load,
  input  wire whu_pkg::whu_cfg_t           i_cfg,
  input  wire logic                        i_flow_en,
  // Words to send to the host
  input  wire logic                        i_tx_valid,
  input  wire logic [whu_pkg::DATA_W-1:0]  i_tx_data,
  output logic                             o_tx_ready,
  // Words received from the host
  output logic                             o_rx_valid,
  output whu_pkg::whu_rx_t                 o_rx,
  input  wire logic                        i_rx_ready,
  output logic                             o_rx_overrun,
  // Autorun decision, caught once after reset
  output logic                             o_autorun_go,
  output logic                             o_autorun_done,
  // Spare modem lines, direction and level set by script
  input  wire logic                        i_spare_a_oe_n,
  input  wire logic                        i_spare_a_out,
  input  wire logic                        i_spare_a_in,
  output logic                             o_spare_a,
  output logic                             o_spare_a_oe_n,
  output logic                             o_spare_a_seen,
  input  wire logic                        i_spare_modem_line_b_oe_n,
  input  wire logic                        i_spare_modem_line_b_out,
  input  wire logic                        i_spare_modem_line_b_in,
  output logic                             o_spare_modem_line_b,
  output logic                             o_spare_modem_line_b_oe_n,
  output logic                             o_spare_modem_line_b_seen,
  // Coexistence pins
  input  wire logic                        i_coex_wlan_busy,
  input  wire logic                        i_coex_bt_priority,
  input  wire logic                        i_coex_bt_state,
  input  wire logic                        i_coex_three_wire,
  output logic                             o_coex_wlan_active,
  output logic                             o_coex_radio_hold,
  // Power-save control
  input  wire logic [2:0]                  i_ps_mode,
  input  wire logic                        i_ps_req,
  input  wire logic                        i_ps_script,
  input  wire logic                        i_adhoc,
  input  wire logic                        i_radio_rx_busy,
  input  wire logic                        i_beacon_tick,
  input  wire logic                        i_wake_pin,
  output logic [2:0]                       o_ps_mode,
  output logic                             o_radio_on,
  output logic                             o_radio_sleep,
  output logic                             o_cpu_standby,
  output logic                             o_ps_refused
);
  import whu_pkg::*;

  // Refuse settings that the counters cannot hold
  if (DIV_INIT < 4 || DIV_INIT >= (1 << DIV_W)) begin : g_div_chk
    $error("DIV_INIT out of range");
  end
  if (READY_CYCLES < 1 || READY_CYCLES >= (1 << READY_W)) begin : g_rdy_chk
    $error("READY_CYCLES out of range");
  end

  localparam logic [DIV_W-1:0]   DIV_RST = DIV_W'(DIV_INIT);
  localparam logic [READY_W-1:0] RDY_MAX = READY_W'(READY_CYCLES);

  // Active line configuration
  whu_cfg_t cfg_q;
  // Held off until the controller is up after reset
  logic [READY_W-1:0] rdy_cnt_q;
  logic               up_q;

  // Configuration register, power-up default 8N1 at the default rate
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= '{div: DIV_RST, parity: PAR_NONE, two_stop: 1'b0};
    end else if (i_cfg_load && i_cfg.div >= DIV_W'(4)) begin
      cfg_q <= i_cfg;
    end
  end

  // Reset settling counter
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdy_cnt_q <= '0;
      up_q      <= 1'b0;
    end else if (!up_q) begin
      rdy_cnt_q <= rdy_cnt_q + READY_W'(1);
      up_q      <= (rdy_cnt_q == RDY_MAX - READY_W'(1));
    end
  end

  // Two-entry receive buffer
  whu_rx_t  rb_mem [2];
  logic     rb_wp_q, rb_rp_q;
  logic [1:0] rb_cnt_q;
  wire      rb_full  = (rb_cnt_q == 2'h2);
  wire      rb_empty = (rb_cnt_q == 2'h0);
  wire      rb_pop   = !rb_empty && i_rx_ready;
  logic     rb_push;
  whu_rx_t  rb_word;

  // Receiver sampling; the wire idles high and a data one is a high wire
  logic [1:0]       rxs_q;            // Input sampled twice for clean edges
  wire              rx_bit = rxs_q[1];
  whu_st_t          rst_q;
  logic [DIV_W-1:0] rcnt_q;
  logic [2:0]       rbit_q;
  logic [7:0]       rsh_q;
  logic             rperr_q, rstop2_q;
  wire              rtick = (rcnt_q == '0);
  wire [DIV_W-1:0]  half  = {1'b0, cfg_q.div[DIV_W-1:1]};

  // Receive framer: start, LSB-first data, parity, stops
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxs_q    <= 2'h3;
      rst_q    <= ST_IDLE;
      rcnt_q   <= '0;
      rbit_q   <= '0;
      rsh_q    <= '0;
      rperr_q  <= 1'b0;
      rstop2_q <= 1'b0;
      rb_push  <= 1'b0;
      rb_word  <= '0;
    end else begin
      rxs_q   <= {rxs_q[0], i_host_txd_n};
      rb_push <= 1'b0;
      rcnt_q  <= rtick ? cfg_q.div - DIV_W'(1) : rcnt_q - DIV_W'(1);
      unique case (rst_q)
        ST_IDLE: if (!rx_bit) begin
          rst_q  <= ST_START;
          rcnt_q <= half;
        end
        ST_START: if (rtick) begin
          rst_q  <= rx_bit ? ST_IDLE : ST_DATA; // False start drops back
          rbit_q <= '0;
        end
        ST_DATA: if (rtick) begin
          rsh_q  <= {rx_bit, rsh_q[7:1]};
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == 3'h7)
            rst_q <= (cfg_q.parity == PAR_NONE) ? ST_STOP : ST_PAR;
          rstop2_q <= cfg_q.two_stop;
        end
        ST_PAR: if (rtick) begin
          rperr_q <= (rx_bit != whu_par(rsh_q, cfg_q.parity));
          rst_q   <= ST_STOP;
        end
        ST_STOP: if (rtick) begin
          if (rstop2_q && rx_bit) begin
            rstop2_q <= 1'b0; // Second stop bit still to check
          end else begin
            rst_q   <= ST_IDLE;
            rb_push <= 1'b1;
            rb_word <= '{data: rsh_q, par_err: rperr_q, frm_err: !rx_bit};
            rperr_q <= 1'b0;
          end
        end
        default: rst_q <= ST_IDLE;
      endcase
    end
  end

  // Buffer pointers; a word arriving when full is counted as overrun
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rb_wp_q      <= 1'b0;
      rb_rp_q      <= 1'b0;
      rb_cnt_q     <= '0;
      o_rx_overrun <= 1'b0;
    end else begin
      if (rb_push && !rb_full) begin
        rb_mem[rb_wp_q] <= rb_word;
        rb_wp_q         <= ~rb_wp_q;
      end
      if (rb_pop)
        rb_rp_q <= ~rb_rp_q;
      rb_cnt_q     <= rb_cnt_q + 2'((rb_push && !rb_full) ? 1 : 0) - 2'(rb_pop ? 1 : 0);
      o_rx_overrun <= rb_push && rb_full;
    end
  end

  // Buffer head; valid follows count so stall never drops a word
  assign o_rx_valid = !rb_empty;
  assign o_rx       = rb_mem[rb_rp_q];

  // With flow control on, receive-ready goes high (deasserted) the cycle after the buffer holds a word,
  // leaving room for one more in flight from a host that reacts late.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_ready_n <= 1'b1;
    end else begin
      o_rx_ready_n <= !up_q || (i_flow_en && !rb_empty);
    end
  end

  // Transmitter
  whu_st_t          tst_q;
  logic [DIV_W-1:0] tcnt_q;
  logic [2:0]       tbit_q;
  logic [7:0]       tsh_q;
  logic             tpar_q, tstop2_q;
  wire              ttick   = (tcnt_q == '0);
  wire              host_ok = !i_flow_en || !i_host_ready_n;
  assign o_tx_ready = (tst_q == ST_IDLE) && up_q && host_ok;

  // Transmit framer; data goes out true, the inverse of cable sense
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tst_q          <= ST_IDLE;
      tcnt_q         <= '0;
      tbit_q         <= '0;
      tsh_q          <= '0;
      tpar_q         <= 1'b0;
      tstop2_q       <= 1'b0;
      o_module_rxd_n <= 1'b1;
    end else begin
      tcnt_q <= ttick ? cfg_q.div - DIV_W'(1) : tcnt_q - DIV_W'(1);
      unique case (tst_q)
        ST_IDLE: if (i_tx_valid && o_tx_ready) begin
          tst_q          <= ST_START;
          tsh_q          <= i_tx_data;
          tpar_q         <= whu_par(i_tx_data, cfg_q.parity);
          tstop2_q       <= cfg_q.two_stop;
          tcnt_q         <= cfg_q.div - DIV_W'(1);
          o_module_rxd_n <= 1'b0;
        end
        ST_START: if (ttick) begin
          tst_q          <= ST_DATA;
          tbit_q         <= '0;
          o_module_rxd_n <= tsh_q[0];
        end
        ST_DATA: if (ttick) begin
          tbit_q <= tbit_q + 3'h1;
          tsh_q  <= {1'b0, tsh_q[7:1]};
          if (tbit_q == 3'h7) begin
            tst_q          <= (cfg_q.parity == PAR_NONE) ? ST_STOP : ST_PAR;
            o_module_rxd_n <= (cfg_q.parity == PAR_NONE) ? 1'b1 : tpar_q;
          end else begin
            o_module_rxd_n <= tsh_q[1];
          end
        end
        ST_PAR: if (ttick) begin
          tst_q          <= ST_STOP;
          o_module_rxd_n <= 1'b1;
        end
        ST_STOP: if (ttick) begin
          if (tstop2_q) tstop2_q <= 1'b0;
          else          tst_q    <= ST_IDLE;
        end
        default: tst_q <= ST_IDLE;
      endcase
    end
  end

  // Autorun strap caught once the settling time has passed
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_autorun_go   <= 1'b0;
      o_autorun_done <= 1'b0;
    end else begin
      o_autorun_go <= 1'b0;
      if (up_q && !o_autorun_done) begin
        o_autorun_done <= 1'b1;
        o_autorun_go   <= i_autorun_inhibit_n;
      end
    end
  end

  // Spare modem lines follow script-set direction and level
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_spare_a                 <= 1'b1;
      o_spare_a_oe_n            <= 1'b0;
      o_spare_a_seen            <= 1'b0;
      o_spare_modem_line_b      <= 1'b1;
      o_spare_modem_line_b_oe_n <= 1'b0;
      o_spare_modem_line_b_seen <= 1'b0;
    end else begin
      o_spare_a                 <= i_spare_a_out;
      o_spare_a_oe_n            <= i_spare_a_oe_n;
      o_spare_a_seen            <= i_spare_a_oe_n ? i_spare_a_in : 1'b0;
      o_spare_modem_line_b      <= i_spare_modem_line_b_out;
      o_spare_modem_line_b_oe_n <= i_spare_modem_line_b_oe_n;
      o_spare_modem_line_b_seen <= i_spare_modem_line_b_oe_n ? i_spare_modem_line_b_in : 1'b0;
    end
  end

  // Coexistence: priority holds the radio; three-wire also honours state
  wire coex_hold = i_coex_bt_priority && (!i_coex_three_wire || i_coex_bt_state);
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_coex_wlan_active <= 1'b0;
      o_coex_radio_hold  <= 1'b0;
    end else begin
      o_coex_wlan_active <= i_coex_wlan_busy && o_radio_on;
      o_coex_radio_hold  <= coex_hold;
    end
  end

  // Power-save request checks: mode 1 needs beacons, mode 6 needs a script
  wire ps_bad = (i_ps_mode == PS_MODE1 && i_adhoc) ||
                (i_ps_mode == PS_MODE6 && !i_ps_script) ||
                !(i_ps_mode inside {PS_OFF, PS_MODE1, PS_MODE5, PS_MODE6});
  wire in_m1  = (o_ps_mode == PS_MODE1);

  // Power-save mode and radio/controller power state
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ps_mode     <= PS_OFF;
      o_ps_refused  <= 1'b0;
      o_radio_on    <= 1'b1;
      o_radio_sleep <= 1'b0;
      o_cpu_standby <= 1'b0;
    end else begin
      o_ps_refused <= i_ps_req && ps_bad;
      if (o_ps_mode == PS_MODE6 && i_wake_pin) begin
        o_ps_mode <= PS_OFF; // Wake pin high wakes from standby
      end else if (i_ps_req && !ps_bad) begin
        o_ps_mode <= i_ps_mode;
      end
      o_radio_on    <= !(o_ps_mode inside {PS_MODE5, PS_MODE6});
      o_cpu_standby <= (o_ps_mode == PS_MODE6);
      // Sleep while not receiving; a beacon tick wakes it for traffic
      o_radio_sleep <= in_m1 && !i_radio_rx_busy && !i_beacon_tick;
    end
  end

  // Receive-ready stays deasserted until settling ends
  a_ready_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !up_q |-> o_rx_ready_n) else $error("ready asserted before settling");
  a_ready_buf: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (up_q && i_flow_en && !rb_empty) |=> o_rx_ready_n) else $error("ready low with data held");
  a_tx_start: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (tst_q == ST_IDLE && i_tx_valid && o_tx_ready) |=> !o_module_rxd_n)
    else $error("start bit missing");
  a_tx_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (tst_q == ST_IDLE && $past(tst_q) == ST_IDLE) |-> o_module_rxd_n)
    else $error("idle line not high");
  a_tx_flow: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_flow_en && i_host_ready_n) |-> !o_tx_ready) else $error("sent while host busy");
  a_m1_adhoc: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_ps_req && i_ps_mode == PS_MODE1 && i_adhoc && !in_m1) |=> !in_m1 && o_ps_refused)
    else $error("mode 1 entered in ad-hoc");
  a_m5_radio: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_ps_mode == PS_MODE5) [*2] |-> !o_radio_on) else $error("radio on in mode 5");
  a_m6_wake: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_ps_mode == PS_MODE6 && i_wake_pin) |=> o_ps_mode == PS_OFF ##1 !o_cpu_standby)
    else $error("no wake on pin");
  a_autorun_once: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_autorun_go |-> $rose(o_autorun_done) && $past(i_autorun_inhibit_n))
    else $error("autorun decision wrong");
endmodule

//--- test/whu_host_model.sv
`timescale 1ns/1ps
// Host UART model: frames words to the device and decodes its output
module whu_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_line_n,
  input  wire logic i_rx_ready_n,
  input  wire logic i_flow,
  input  wire logic i_stall,
  output logic      o_txd_n,
  output logic      o_host_ready_n
);
  int unsigned div      = 16;   // Cycles per bit, kept in step by the bench
  logic [1:0]  par      = 2'h0; // Parity mode
  logic        two_stop = 1'h0; // Second stop bit
  logic [9:0]  got_q[$];        // Decoded words {stop_ok, par_ok, data}

  initial o_txd_n = 1'h1;
  // A busy host raises its ready line
  assign o_host_ready_n = i_stall;

  // Parity over a word, even unless odd is set
  function automatic logic par_of(input logic [7:0] d);
    return (par == whu_pkg::PAR_ODD) ? ~(^d) : (^d);
  endfunction

  // One bit time on either edge
  task automatic rw;
    repeat (div) @(posedge i_ref_clk);
  endtask
  task automatic tw;
    repeat (div) @(negedge i_ref_clk);
  endtask

  // Decode device frames, sampling each bit in mid-cell
  initial begin : rx_proc
    logic [7:0] d;
    logic       pok;
    logic       sok;
    forever begin
      @(negedge i_line_n);
      repeat (div / 2) @(posedge i_ref_clk);
      for (int i = 0; i < 8; i++) begin
        rw();
        d[i] = i_line_n;
      end
      pok = 1'h1;
      if (par != whu_pkg::PAR_NONE) begin
        rw();
        pok = (i_line_n == par_of(d));
      end
      rw();
      sok = i_line_n;
      if (two_stop) begin
        rw();
        sok = sok & i_line_n;
      end
      got_q.push_back({sok, pok, d});
    end
  end

  // Send one frame; waits for the device's ready when flow control is on
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    for (int k = 0; k < 20000 && i_flow && i_rx_ready_n; k++) @(negedge i_ref_clk);
    if (i_flow && i_rx_ready_n) whu_uart_tb.mismatches++; // Spent wait
    @(negedge i_ref_clk);
    o_txd_n = 1'h0;
    tw();
    for (int i = 0; i < 8; i++) begin
      o_txd_n = b[i];
      tw();
    end
    if (par != whu_pkg::PAR_NONE) begin
      o_txd_n = par_of(b) ^ bad_par;
      tw();
    end
    // A low first stop cell makes a broken frame; the rest stays high
    o_txd_n = ~bad_stop;
    tw();
    o_txd_n = 1'h1;
    repeat (two_stop ? 2 : 1) tw();
  endtask
endmodule

//--- test/whu_uart_tb.sv
`timescale 1ns/1ps
// Self-checking bench: controller side driven here, serial side by a host model
module whu_uart_tb;
  localparam int unsigned DIV = 16; // Short bit time keeps the run brief
  localparam int unsigned RC  = 4;  // Short settling count
  logic i_ref_clk, i_resetn, i_host_txd_n, i_host_ready_n, i_autorun_inhibit_n;
  logic i_cfg_load, i_flow_en, i_tx_valid, i_rx_ready, i_ps_req, i_ps_script, i_adhoc;
  logic i_wake_pin, i_spare_a_oe_n, i_spare_a_out, i_spare_a_in, i_spare_modem_line_b_oe_n;
  logic i_spare_modem_line_b_out, i_spare_modem_line_b_in, i_coex_wlan_busy, stall;
  logic i_coex_bt_priority, i_coex_bt_state, i_coex_three_wire, i_radio_rx_busy;
  logic i_beacon_tick, o_module_rxd_n, o_rx_ready_n, o_tx_ready, o_rx_valid, o_rx_overrun;
  logic o_autorun_go, o_autorun_done, o_spare_a, o_spare_a_oe_n, o_spare_a_seen;
  logic o_spare_modem_line_b, o_spare_modem_line_b_oe_n, o_spare_modem_line_b_seen;
  logic o_coex_wlan_active, o_coex_radio_hold, o_radio_on, o_radio_sleep, o_cpu_standby;
  logic o_ps_refused;
  logic [7:0]        i_tx_data;
  logic [2:0]        i_ps_mode, o_ps_mode;
  whu_pkg::whu_cfg_t i_cfg;
  whu_pkg::whu_rx_t  o_rx;
  int          mismatches = 0;           // Failed comparisons
  int          cmp_count  = 0;           // All comparisons
  int          go_cnt, ovr_cnt, ref_cnt; // Pulse counts
  logic [31:0] seed = 32'h948567AE;      // Random state

  whu_uart #(.DIV_INIT(DIV), .READY_CYCLES(RC)) whu_uart_inst (.*);
  whu_host_model whu_host_model_inst (.i_ref_clk, .i_line_n(o_module_rxd_n),
    .i_rx_ready_n(o_rx_ready_n), .i_flow(i_flow_en), .i_stall(stall),
    .o_txd_n(i_host_txd_n), .o_host_ready_n(i_host_ready_n));

  initial begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Pulses counted at the edge after they rise
  always @(posedge i_ref_clk) begin
    go_cnt <= go_cnt + (o_autorun_go === 1'h1);
    ovr_cnt <= ovr_cnt + (o_rx_overrun === 1'h1);
    ref_cnt <= ref_cnt + (o_ps_refused === 1'h1);
  end
  // Hang guard, well above the expected run
  initial begin
    #900000;
    mismatches++;
    results();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One cycle of a bounded wait; a spent bound ends the run
  task automatic tick(inout int k);
    step(1);
    k++;
    if (k > 20000) begin
      mismatches++;
      results();
    end
  endtask
  // Reset for ten cycles, then time the ready line and the autorun pulse
  task automatic reset_dut(input logic inh);
    int k = 0;
    i_resetn = 1'h0;
    i_autorun_inhibit_n = inh;
    step(10);
    check({o_module_rxd_n, o_rx_ready_n, o_ps_mode, o_radio_on}, 6'h31, "reset");
    {go_cnt, ovr_cnt, ref_cnt} = '0;
    i_resetn = 1'h1;
    while (o_rx_ready_n !== 1'h0) tick(k);
    check(k >= RC && k <= RC + 3, 1'h1, "settle");
    step(4);
    check(go_cnt, inh, "autorun");
    check(o_autorun_done, 1'h1, "autorun decided");
  endtask
  // Load a line setting into both ends
  task automatic cfg(input logic [1:0] p, input logic ts, input int d);
    i_cfg = '{div: d[15:0], parity: p, two_stop: ts};
    i_cfg_load = 1'h1;
    step(1);
    i_cfg_load = 1'h0;
    whu_host_model_inst.div = d;
    whu_host_model_inst.par = p;
    whu_host_model_inst.two_stop = ts;
  endtask
  task automatic tx(input logic [7:0] b);
    int k = 0;
    i_tx_valid = 1'h1;
    i_tx_data = b;
    while (o_tx_ready !== 1'h1) tick(k);
    step(1);
    i_tx_valid = 1'h0;
  endtask
  task automatic pop(input logic [9:0] e);
    int k = 0;
    while (o_rx_valid !== 1'h1) tick(k);
    check(o_rx, e, "word from host");
    i_rx_ready = 1'h1;
    step(1);
    i_rx_ready = 1'h0;
  endtask
  // One word each way; the host sends the inverse back
  task automatic xfer(input logic [7:0] b, input logic bp, input logic bs);
    int k = 0;
    tx(b);
    while (whu_host_model_inst.got_q.size() == 0) tick(k);
    check(whu_host_model_inst.got_q.pop_front(), {2'h3, b}, "word to host");
    whu_host_model_inst.send(~b, bp, bs);
    pop({~b, bp, bs});
  endtask
  // Mode request; refused when the mode does not change to it
  task automatic ps(input logic [2:0] md, input logic ah, input logic sc, input logic [2:0] em);
    int r = ref_cnt;
    {i_ps_mode, i_adhoc, i_ps_script, i_ps_req} = {md, ah, sc, 1'h1};
    step(1);
    i_ps_req = 1'h0;
    step(3);
    check(o_ps_mode, em, "power mode");
    check(ref_cnt - r, em != md, "refusal");
    check({o_radio_on, o_cpu_standby}, {em < 3'h2, em == 3'h6}, "radio");
  endtask

  // Main sequence
  initial begin
    {i_resetn, i_cfg_load, i_tx_valid, i_rx_ready, i_ps_req, i_ps_script, i_adhoc} = '0;
    {i_wake_pin, i_coex_wlan_busy, i_coex_bt_priority, i_coex_bt_state, stall} = '0;
    {i_coex_three_wire, i_radio_rx_busy, i_beacon_tick, i_tx_data, i_ps_mode} = '0;
    {i_spare_a_oe_n, i_spare_a_out, i_spare_a_in, i_spare_modem_line_b_oe_n} = '0;
    {i_spare_modem_line_b_out, i_spare_modem_line_b_in, i_cfg} = '0;
    i_flow_en = 1'h1;
    reset_dut(1'h1);
    // Power-up framing: eight bits, no parity, one stop
    xfer(8'h00, 1'h0, 1'h0);
    xfer(8'hFF, 1'h0, 1'h0);
    seed = lfsr(seed);
    xfer(seed[7:0], 1'h0, 1'h0);
    $display("default framing test done");
    // Each parity and stop setting at a random divider, with a bad parity bit where parity is on
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 2; s++) begin
        seed = lfsr(seed);
        cfg(p[1:0], s[0], 8 + seed[11:8]);
        xfer(seed[7:0], 1'h0, 1'h0);
        if (p != 0) xfer(seed[15:8], 1'h1, 1'h0);
      end
    end
    xfer(seed[23:16], 1'h0, 1'h1);
    $display("line setting test done");
    // A busy host holds off the transmitter only with flow control on
    stall = 1'h1;
    step(3);
    check(o_tx_ready, 1'h0, "host busy");
    i_flow_en = 1'h0;
    step(3);
    check(o_tx_ready, 1'h1, "flow off");
    stall = 1'h0;
    i_flow_en = 1'h1;
    // Fill the two-entry buffer past its end, then drain it
    whu_host_model_inst.send(8'hA5, 1'h0, 1'h0);
    step(4);
    check(o_rx_ready_n, 1'h1, "ready drops");
    i_flow_en = 1'h0;
    whu_host_model_inst.send(8'h5A, 1'h0, 1'h0);
    whu_host_model_inst.send(8'h3C, 1'h0, 1'h0);
    check(ovr_cnt, 1'h1, "overrun");
    pop({8'hA5, 2'h0});
    pop({8'h5A, 2'h0});
    check(o_rx_valid, 1'h0, "empty");
    i_flow_en = 1'h1;
    step(3);
    check(o_rx_ready_n, 1'h0, "ready again");
    $display("flow and buffer test done");
    // Power-save modes, refusals and pin wake
    ps(3'h1, 1'h1, 1'h0, 3'h0);
    ps(3'h1, 1'h0, 1'h0, 3'h1);
    check(o_radio_sleep, 1'h1, "idle radio sleeps");
    i_radio_rx_busy = 1'h1;
    step(2);
    check(o_radio_sleep, 1'h0, "radio receiving");
    {i_radio_rx_busy, i_beacon_tick} = 2'h1;
    step(2);
    check(o_radio_sleep, 1'h0, "beacon wake");
    i_beacon_tick = 1'h0;
    ps(3'h5, 1'h0, 1'h0, 3'h5);
    ps(3'h6, 1'h0, 1'h0, 3'h5);
    ps(3'h3, 1'h0, 1'h0, 3'h5);
    ps(3'h6, 1'h0, 1'h1, 3'h6);
    i_wake_pin = 1'h1;
    step(2);
    check(o_ps_mode, 3'h0, "pin wake");
    i_wake_pin = 1'h0;
    $display("power test done");
    // Random coexistence and spare line traffic
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      {i_coex_wlan_busy, i_coex_bt_priority, i_coex_bt_state, i_coex_three_wire} = seed[3:0];
      {i_spare_a_oe_n, i_spare_a_out, i_spare_a_in} = seed[6:4];
      {i_spare_modem_line_b_oe_n, i_spare_modem_line_b_out, i_spare_modem_line_b_in} = seed[9:7];
      step(2);
      check(o_coex_wlan_active, seed[3], "wlan active");
      check(o_coex_radio_hold, seed[2] & (~seed[0] | seed[1]), "radio hold");
      check({o_spare_a, o_spare_a_oe_n, o_spare_a_seen}, {seed[5], seed[6], seed[6] & seed[4]},
        "spare a");
      check({o_spare_modem_line_b, o_spare_modem_line_b_oe_n, o_spare_modem_line_b_seen},
        {seed[8], seed[9], seed[9] & seed[7]}, "spare b");
    end
    $display("pin test done");
    reset_dut(1'h0);
    $display("second reset test done");
    results();
  end
endmodule
